// ### fpm_pkg.sv
// Purpose: Constants for the fieldbus process data map block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Stream window holds up to 32 words of beam bits.

package fpm_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] FPM_OFS_CTRL    = 8'h00;
   localparam logic [7:0] FPM_OFS_SEL0    = 8'h04;
   localparam logic [7:0] FPM_OFS_SEL1    = 8'h08;
   localparam logic [7:0] FPM_OFS_RES0    = 8'h0c;
   localparam logic [7:0] FPM_OFS_RES1    = 8'h10;
   localparam logic [7:0] FPM_OFS_SCFG    = 8'h14;
   localparam logic [7:0] FPM_OFS_STAT    = 8'h18;
   localparam logic [7:0] FPM_OFS_STREAM  = 8'h80;

   // ==========================================================
   // Field positions
   localparam int FPM_CTRL_TRIG_LSB   = 0;
   localparam int FPM_CTRL_TEACH_LSB  = 8;
   localparam int FPM_SCFG_SIZE_LSB   = 0;
   localparam int FPM_SCFG_GROUP_LSB  = 8;
   localparam int FPM_STAT_GRPERR     = 0;
   localparam int FPM_STAT_SELERR     = 1;
   localparam int FPM_SW_CYCLE_MSB    = 11;
   localparam int FPM_SW_EVENT        = 14;
   localparam int FPM_SW_VALID        = 15;

   // ==========================================================
   // Sizes and reset values
   localparam int FPM_NUM_EVAL        = 2;
   localparam int FPM_NUM_BEAMS       = 1776;
   localparam int FPM_BEAMS_PER_GROUP = 16;
   localparam logic [15:0] FPM_SEL_RST   = 16'h0000;
   localparam logic [15:0] FPM_SEL_MAX   = 16'h000d;
   localparam logic [7:0]  FPM_GROUP_RST = 8'h01;
   localparam logic [2:0]  FPM_SIZE_RST  = 3'h0;
   localparam logic [2:0]  FPM_SIZE_MAX  = 3'h6;

   // Highest legal group index per stream size code (16 .. 1024 beams)
   localparam logic [7:0] FPM_GROUP_MAX [0:6] =
      '{8'h6f, 8'h6e, 8'h6c, 8'h68, 8'h60, 8'h50, 8'h30};

   // ==========================================================
   // Evaluation selections
   typedef enum logic [15:0] {
      FPM_SEL_NONE    = 16'h0000,
      FPM_SEL_FB      = 16'h0001,
      FPM_SEL_FC      = 16'h0002,
      FPM_SEL_LB      = 16'h0003,
      FPM_SEL_LC      = 16'h0004,
      FPM_SEL_TB      = 16'h0005,
      FPM_SEL_TC      = 16'h0006,
      FPM_SEL_AREA_LO = 16'h0009,
      FPM_SEL_AREA_HI = 16'h000a,
      FPM_SEL_IO      = 16'h000b,
      FPM_SEL_RSVD    = 16'h000c,
      FPM_SEL_STATUS  = 16'h000d
   } fpm_sel_t;

endpackage

// ### fpm_top.sv
// Purpose: Cyclic process data map of a measuring light curtain.
// Assumes: Beam evaluation results arrive as synchronous inputs.
// Notes:   Control bytes, evaluation words and beam stream over APB.

`timescale 1ns/1ps

module fpm_top
   import fpm_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Beam evaluation results
   input  wire logic [15:0]              first_blocked_beam,
   input  wire logic [15:0]              first_clear_beam,
   input  wire logic [15:0]              last_blocked_beam,
   input  wire logic [15:0]              last_clear_beam,
   input  wire logic [15:0]              blocked_beam_total,
   input  wire logic [15:0]              clear_beam_total,
   input  wire logic [31:0]              area_status,
   input  wire logic [15:0]              io_status,
   input  wire logic [11:0]              cycle_number,
   input  wire logic [7:0]               device_status,
   input  wire logic                     result_valid,
   input  wire logic [FPM_NUM_BEAMS-1:0] beam_blocked,
   // Commands
   output logic                          trigger_pulse,
   output logic                          teach_pulse
);

   // ==========================================================
   // Bus decode
   wire        acc      = ce && psel && penable && !pready;
   wire        wr       = acc && pwrite;
   wire        in_strm  = paddr[7];
   wire        hit_ctrl = paddr == FPM_OFS_CTRL;
   wire        hit_sel0 = paddr == FPM_OFS_SEL0;
   wire        hit_sel1 = paddr == FPM_OFS_SEL1;
   wire        hit_res0 = paddr == FPM_OFS_RES0;
   wire        hit_res1 = paddr == FPM_OFS_RES1;
   wire        hit_scfg = paddr == FPM_OFS_SCFG;
   wire        hit_stat = paddr == FPM_OFS_STAT;
   wire        mapped   = (hit_ctrl || hit_sel0 || hit_sel1 || hit_res0 ||
                           hit_res1 || hit_scfg || hit_stat || in_strm) &&
                          (paddr[1:0] == 2'h0);
   // Result words and stream data are read-only
   wire        ro_hit   = hit_res0 || hit_res1 || hit_stat || in_strm;
   wire        bad      = !mapped || (pwrite && ro_hit);
   wire        wr_ok    = wr && !bad;

   // ==========================================================
   // Control bytes
   logic [7:0] trig_last_r;
   logic [7:0] teach_last_r;
   wire        wr_ctrl   = wr_ok && hit_ctrl;
   wire [7:0]  trig_byte = pwdata[FPM_CTRL_TRIG_LSB +: 8];
   wire [7:0]  teach_byte = pwdata[FPM_CTRL_TEACH_LSB +: 8];
   // 8-bit add wraps 255 to 0, so that roll-over still counts
   wire        trig_inc  = wr_ctrl &&
                           (trig_byte == trig_last_r + 8'h01);
   wire        teach_inc = wr_ctrl &&
                           (teach_byte == teach_last_r + 8'h01);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_last_r   <= 8'h00;
         teach_last_r  <= 8'h00;
         trigger_pulse <= 1'b0;
         teach_pulse   <= 1'b0;
      end else if (ce) begin
         trigger_pulse <= trig_inc;
         teach_pulse   <= teach_inc;
         if (wr_ctrl) begin
            trig_last_r  <= trig_byte;
            teach_last_r <= teach_byte;
         end
      end
   end

   // ==========================================================
   // Status word event flag
   logic [7:0] status_prev_r;
   logic       event_r;
   wire        status_chg = device_status != status_prev_r;
   // A change in the same cycle as a return to zero keeps the flag set
   wire        event_nxt  = status_chg ? 1'b1 :
                            (device_status == 8'h00) ? 1'b0 : event_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_prev_r <= 8'h00;
         event_r       <= 1'b0;
      end else if (ce) begin
         status_prev_r <= device_status;
         event_r       <= event_nxt;
      end
   end

   wire [15:0] status_word = {result_valid, event_r, 2'b00,
                              cycle_number};

   // ==========================================================
   // Evaluation instances, each with its own selection
   logic [15:0] sel_r  [FPM_NUM_EVAL];
   logic [15:0] eval_w [FPM_NUM_EVAL];
   logic [FPM_NUM_EVAL-1:0] sel_bad;
   wire  [FPM_NUM_EVAL-1:0] wr_sel = {hit_sel1, hit_sel0} &
                                     {FPM_NUM_EVAL{wr_ok}};

   genvar g;
   generate
      for (g = 0; g < FPM_NUM_EVAL; g++) begin : g_eval
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               sel_r[g] <= FPM_SEL_RST;
            end else if (ce && wr_sel[g]) begin
               sel_r[g] <= pwdata[15:0];
            end
         end

         always_comb begin
            unique case (sel_r[g])
               FPM_SEL_FB:      eval_w[g] = first_blocked_beam;
               FPM_SEL_FC:      eval_w[g] = first_clear_beam;
               FPM_SEL_LB:      eval_w[g] = last_blocked_beam;
               FPM_SEL_LC:      eval_w[g] = last_clear_beam;
               FPM_SEL_TB:      eval_w[g] = blocked_beam_total;
               FPM_SEL_TC:      eval_w[g] = clear_beam_total;
               FPM_SEL_AREA_LO: eval_w[g] = area_status[15:0];
               FPM_SEL_AREA_HI: eval_w[g] = area_status[31:16];
               FPM_SEL_IO:      eval_w[g] = io_status;
               FPM_SEL_STATUS:  eval_w[g] = status_word;
               // None, reserved and out-of-range codes answer zero
               default:         eval_w[g] = 16'h0000;
            endcase
         end

         assign sel_bad[g] = (sel_r[g] > FPM_SEL_MAX) ||
                             (sel_r[g] == FPM_SEL_RSVD) ||
                             (sel_r[g] == 16'h0007) ||
                             (sel_r[g] == 16'h0008);
      end
   endgenerate

   // ==========================================================
   // Beam stream configuration
   logic [2:0] size_r;
   logic [7:0] group_r;
   wire        wr_scfg = wr_ok && hit_scfg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         size_r  <= FPM_SIZE_RST;
         group_r <= FPM_GROUP_RST;
      end else if (ce && wr_scfg) begin
         size_r  <= (pwdata[FPM_SCFG_SIZE_LSB +: 3] > FPM_SIZE_MAX) ?
                    FPM_SIZE_MAX : pwdata[FPM_SCFG_SIZE_LSB +: 3];
         group_r <= pwdata[FPM_SCFG_GROUP_LSB +: 8];
      end
   end

   // Limits per size: 111, 110, 108, 104, 96, 80, 48 groups
   wire [7:0]  group_max = FPM_GROUP_MAX[size_r];
   wire        group_ok  = (group_r != 8'h00) &&
                           (group_r <= group_max);
   wire [10:0] beam_cnt  = 11'(FPM_BEAMS_PER_GROUP) << size_r;

   // ==========================================================
   // Beam stream window
   // Index 0 holds beam 1; start is 16*(i-1) beams in
   wire [10:0] start_idx = 11'(group_r - 8'h01) << 4;
   wire [4:0]  word_idx  = paddr[6:2];
   wire [10:0] word_base = {1'b0, word_idx, 5'h00};
   wire [11:0] bit_base  = {1'b0, start_idx} + {1'b0, word_base};
   // Padding keeps the part-select inside the vector on any address
   wire [FPM_NUM_BEAMS+2047:0] beams_ext =
      {2048'h0, beam_blocked};
   wire [31:0] raw_word  = beams_ext[bit_base +: 32];
   wire [31:0] bit_live;

   generate
      for (g = 0; g < 32; g++) begin : g_mask
         assign bit_live[g] = (word_base + 11'(g)) < beam_cnt;
      end
   endgenerate

   wire [31:0] strm_word = group_ok ? (raw_word & bit_live) : 32'h0;

   // ==========================================================
   // Read mux
   wire [31:0] stat_word = {30'h0, |sel_bad, !group_ok};
   wire [31:0] rd_mux =
      in_strm  ? strm_word :
      hit_ctrl ? {16'h0, teach_last_r, trig_last_r} :
      hit_sel0 ? {16'h0, sel_r[0]} :
      hit_sel1 ? {16'h0, sel_r[1]} :
      hit_res0 ? {16'h0, eval_w[0]} :
      hit_res1 ? {16'h0, eval_w[1]} :
      hit_scfg ? {16'h0, group_r, 5'h00, size_r} :
      hit_stat ? stat_word : 32'h0;

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else if (ce) begin
         pready  <= acc;
         pslverr <= acc && bad;
         if (acc && !pwrite) begin
            prdata <= bad ? 32'h0 : rd_mux;
         end
      end
   end

   // ==========================================================
   // Checks
   sequence s_access;
      ce && psel && penable && !pready;
   endsequence

   sequence s_err_answer;
      pready && pslverr;
   endsequence

   chk_trig_incr: assert property (@(posedge clk) disable iff (rst)
      ce && trig_inc |=> trigger_pulse)
      else $error("trigger increment did not start command");

   chk_trig_same: assert property (@(posedge clk) disable iff (rst)
      ce && wr_ctrl && trig_byte == trig_last_r |=> !trigger_pulse)
      else $error("unchanged trigger byte started command");

   chk_teach_wrap: assert property (@(posedge clk) disable iff (rst)
      ce && wr_ctrl && teach_last_r == 8'hff && teach_byte == 8'h00
      |=> teach_pulse)
      else $error("teach byte wrap not seen as increment");

   chk_event_set: assert property (@(posedge clk) disable iff (rst)
      ce && status_chg |=> event_r)
      else $error("status change did not raise event flag");

   chk_event_clear: assert property (@(posedge clk) disable iff (rst)
      ce && device_status == 8'h00 && !status_chg |=> !event_r)
      else $error("event flag stayed set at zero status");

   chk_valid_bit: assert property (@(posedge clk) disable iff (rst)
      sel_r[0] == FPM_SEL_STATUS |->
      eval_w[0][FPM_SW_VALID] == result_valid &&
      eval_w[0][13:12] == 2'b00)
      else $error("status word valid bit wrong");

   chk_sel_none: assert property (@(posedge clk) disable iff (rst)
      sel_r[0] == FPM_SEL_NONE |-> eval_w[0] == 16'h0000)
      else $error("no evaluation did not answer zero");

   chk_group_zero: assert property (@(posedge clk) disable iff (rst)
      ce && wr_scfg && pwdata[15:8] == 8'h00 |=> !group_ok)
      else $error("group index zero accepted");

   chk_size_limit: assert property (@(posedge clk) disable iff (rst)
      size_r == FPM_SIZE_MAX && group_r == 8'h31 |-> !group_ok)
      else $error("1024-beam group above 48 accepted");

   chk_unmapped: assert property (@(posedge clk) disable iff (rst)
      s_access and !mapped |=> s_err_answer)
      else $error("unmapped address not answered with error");

   chk_apb_ready: assert property (@(posedge clk) disable iff (rst)
      s_access |=> pready ##1 !pready)
      else $error("access not answered in one wait state");

   chk_ro_write: assert property (@(posedge clk) disable iff (rst)
      s_access and (pwrite && ro_hit) |=> s_err_answer)
      else $error("write to read-only word not refused");

   chk_read_zero: assert property (@(posedge clk) disable iff (rst)
      s_access and (!pwrite && bad) |=> prdata == 32'h0)
      else $error("refused read returned data");

   chk_teach_incr: assert property (@(posedge clk) disable iff (rst)
      ce && teach_inc |=> teach_pulse)
      else $error("teach increment did not start command");

   chk_teach_same: assert property (@(posedge clk) disable iff (rst)
      ce && wr_ctrl && teach_byte == teach_last_r |=> !teach_pulse)
      else $error("unchanged teach byte started command");

   chk_trig_wrap: assert property (@(posedge clk) disable iff (rst)
      ce && wr_ctrl && trig_last_r == 8'hff && trig_byte == 8'h00
      |=> trigger_pulse)
      else $error("trigger byte wrap not seen as increment");

   // A write needs three cycles, so a pulse can never be followed by one
   chk_pulse_once: assert property (@(posedge clk) disable iff (rst)
      ce && (trigger_pulse || teach_pulse) |=> !trigger_pulse && !teach_pulse)
      else $error("command pulse longer than one cycle");

   chk_pulse_write: assert property (@(posedge clk) disable iff (rst)
      ce && !wr_ctrl |=> !trigger_pulse && !teach_pulse)
      else $error("command pulse without control write");

   chk_ctrl_store: assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> trig_last_r == $past(trig_byte) &&
      teach_last_r == $past(teach_byte))
      else $error("control byte not remembered");

   chk_event_hold: assert property (@(posedge clk) disable iff (rst)
      ce && !status_chg && device_status != 8'h00
      |=> event_r == $past(event_r))
      else $error("event flag changed without cause");

   chk_status_cycle: assert property (@(posedge clk) disable iff (rst)
      sel_r[1] == FPM_SEL_STATUS |->
      eval_w[1][FPM_SW_CYCLE_MSB:0] == cycle_number &&
      eval_w[1][FPM_SW_EVENT] == event_r)
      else $error("status word cycle number wrong");

   chk_area_low: assert property (@(posedge clk) disable iff (rst)
      sel_r[0] == FPM_SEL_AREA_LO |-> eval_w[0] == area_status[15:0])
      else $error("low area status not returned");

   chk_area_high: assert property (@(posedge clk) disable iff (rst)
      sel_r[0] == FPM_SEL_AREA_HI |-> eval_w[0] == area_status[31:16])
      else $error("high area status not returned");

   chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      sel_r[1] == FPM_SEL_RSVD |-> eval_w[1] == 16'h0000)
      else $error("reserved selection answered data");

   chk_sel_store: assert property (@(posedge clk) disable iff (rst)
      wr_sel[0] |=> sel_r[0] == $past(pwdata[15:0]))
      else $error("selection write not stored");

   chk_stream_off: assert property (@(posedge clk) disable iff (rst)
      !group_ok |-> strm_word == 32'h0)
      else $error("stream data with group out of range");

   chk_stream_tail: assert property (@(posedge clk) disable iff (rst)
      word_base >= beam_cnt |-> strm_word == 32'h0)
      else $error("stream bits beyond module size");

   chk_size_clamp: assert property (@(posedge clk) disable iff (rst)
      wr_scfg && pwdata[2:0] == 3'h7 |=> size_r == FPM_SIZE_MAX)
      else $error("stream size code not clamped");

endmodule

// ### fpm_apb_master.sv
// Purpose: APB master standing in for the fieldbus controller.
// Assumes: Slave ends every access with pready.
// Notes:   All changes follow a rising edge; wait bound is 50 cycles.

`timescale 1ns/1ps

module fpm_apb_master (
   // Clock
   input  wire logic        clk,
   // APB
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // ==========================================================
   // One transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      ok = (pready === 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the process data map.
// Assumes: ce held high; beam pattern fixed from time zero.
// Notes:   Pulses are counted, so a stretched pulse shows as extra.

`timescale 1ns/1ps

module testbench import fpm_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, trig, teach;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] fb = 16'h0101, fc = 16'h0202, lb = 16'h0303;
   logic [15:0] lc = 16'h0404, tb = 16'h0505, tc = 16'h0606;
   logic [15:0] io = 16'h1111;
   logic [31:0] area = 32'h0a0b0c0d;
   logic [11:0] cyc = 12'habc;
   logic [7:0] dstat = 8'h00;
   logic valid = 1'b1;
   logic [FPM_NUM_BEAMS-1:0] beams;
   int bad_count = 0, compares = 0, trig_n = 0, teach_n = 0;

   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (trig === 1'b1) trig_n++;
      if (teach === 1'b1) teach_n++;
   end

   fpm_apb_master m (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   fpm_top uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .first_blocked_beam(fb),
      .first_clear_beam(fc), .last_blocked_beam(lb),
      .last_clear_beam(lc), .blocked_beam_total(tb),
      .clear_beam_total(tc), .area_status(area), .io_status(io),
      .cycle_number(cyc), .device_status(dstat), .result_valid(valid),
      .beam_blocked(beams), .trigger_pulse(trig), .teach_pulse(teach));

   // ==========================================================
   // Helpers
   task automatic finish_test();
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      logic ok;
      m.xfer(w, a, d, r, e, ok);
      if (!ok) begin
         bad_count++;
         finish_test();
      end
   endtask

   function automatic logic pat(int k);
      return (k % 3 == 0) ^ (k % 7 == 1);
   endfunction

   // Word n of the stream for group g and size code s
   function automatic logic [31:0] ew(int g, int s, int n);
      logic [31:0] w;
      w = 32'h0;
      for (int j = 0; j < 32; j++)
         if (32 * n + j < (16 << s)) w[j] = pat(16 * (g - 1) + 32 * n + j);
      return w;
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      acc(0, FPM_OFS_CTRL, 0, r, e);
      check(r, 32'h0);
      acc(0, FPM_OFS_SEL0, 0, r, e);
      check(r, 32'h0);
      acc(0, FPM_OFS_SCFG, 0, r, e);
      check(r, 32'h0100);
      check({31'h0, e}, 32'h0);
   endtask

   task automatic t_cmd();
      // The sixth write wraps the trigger byte and the last the teach byte from 255 to 0
      logic [31:0] cw [8] = '{32'h0001, 32'h0001, 32'h0102, 32'h0304,
                              32'h04ff, 32'h0400, 32'hff01, 32'h0002};
      int dt [8] = '{1, 0, 1, 0, 0, 1, 1, 1};
      int dh [8] = '{0, 0, 1, 0, 1, 0, 0, 1};
      int t0, h0;
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 8; i++) begin
         t0 = trig_n;
         h0 = teach_n;
         acc(1, FPM_OFS_CTRL, cw[i], r, e);
         repeat (2) @(posedge clk);
         check(trig_n - t0, dt[i]);
         check(teach_n - h0, dh[i]);
      end
      acc(0, FPM_OFS_CTRL, 0, r, e);
      check(r, 32'h0002);
   endtask

   task automatic t_sel();
      logic [15:0] ex [14] = '{16'h0, 16'h0101, 16'h0202, 16'h0303,
         16'h0404, 16'h0505, 16'h0606, 16'h0, 16'h0, 16'h0c0d,
         16'h0a0b, 16'h1111, 16'h0, 16'h8abc};
      logic [31:0] r;
      logic e;
      for (int s = 0; s < 14; s++) begin
         acc(1, FPM_OFS_SEL0, s, r, e);
         acc(1, FPM_OFS_SEL1, 13 - s, r, e);
         acc(0, FPM_OFS_RES0, 0, r, e);
         check(r, {16'h0, ex[s]});
         acc(0, FPM_OFS_RES1, 0, r, e);
         check(r, {16'h0, ex[13 - s]});
      end
      acc(1, FPM_OFS_SEL1, 14, r, e);
      acc(0, FPM_OFS_STAT, 0, r, e);
      check(r & 32'h2, 32'h2);
   endtask

   task automatic t_event();
      logic [31:0] r;
      logic e;
      acc(1, FPM_OFS_SEL0, 13, r, e);
      @(posedge clk);
      dstat <= 8'h05;
      repeat (3) @(posedge clk);
      acc(0, FPM_OFS_RES0, 0, r, e);
      check(r, 32'hcabc);
      dstat <= 8'h00;
      valid <= 1'b0;
      repeat (3) @(posedge clk);
      acc(0, FPM_OFS_RES0, 0, r, e);
      check(r, 32'h0abc);
   endtask

   task automatic t_stream();
      int gmax [7] = '{111, 110, 108, 104, 96, 80, 48};
      int lo, hi;
      logic [31:0] r;
      logic e;
      for (int s = 0; s < 7; s++) begin
         acc(1, FPM_OFS_SCFG, (gmax[s] << 8) | s, r, e);
         lo = (s == 0) ? 0 : (1 << s) / 2 - 1;
         hi = (s == 6) ? 31 : ((s == 0) ? 1 : (1 << s) / 2);
         for (int n = 0; n <= hi; n = (n == 0) ? lo + (lo == 0) : n + 1) begin
            acc(0, FPM_OFS_STREAM + 8'(4 * n), 0, r, e);
            check(r, ew(gmax[s], s, n));
         end
      end
      acc(1, FPM_OFS_SCFG, 32'h3106, r, e);
      acc(0, FPM_OFS_STREAM, 0, r, e);
      check(r, 32'h0);
      acc(0, FPM_OFS_STAT, 0, r, e);
      check(r & 32'h1, 32'h1);
      // Group zero is never legal; size code 7 clamps to 1024 beams
      acc(1, FPM_OFS_SCFG, 32'h0007, r, e);
      acc(0, FPM_OFS_SCFG, 0, r, e);
      check(r, 32'h0006);
      acc(0, FPM_OFS_STAT, 0, r, e);
      check(r & 32'h1, 32'h1);
   endtask

   task automatic t_err();
      logic [31:0] r;
      logic e;
      acc(0, 8'h1c, 0, r, e);
      check({31'h0, e}, 32'h1);
      acc(1, FPM_OFS_RES0, 32'h1234, r, e);
      check({31'h0, e}, 32'h1);
      acc(0, 8'h06, 0, r, e);
      check({31'h0, e}, 32'h1);
   endtask

   initial begin
      for (int k = 0; k < FPM_NUM_BEAMS; k++) beams[k] = pat(k);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_cmd();
      t_sel();
      t_event();
      t_stream();
      t_err();
      finish_test();
   end
endmodule
